//--- design/pcg_pkg.sv
// Package with offsets, field positions and reset values of the port clock gate block
package pcg_pkg;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [11:0] PCG_OFS_RUN_CFG = 12'h060;
    localparam logic [11:0] PCG_OFS_RUN_GATE = 12'h108;
    localparam logic [11:0] PCG_OFS_SLEEP_GATE = 12'h118;
    localparam logic [11:0] PCG_OFS_DEEP_GATE = 12'h128;
    localparam logic [11:0] PCG_OFS_IRQ_STATUS = 12'h200;
    localparam logic [11:0] PCG_OFS_IRQ_ENABLE = 12'h204;
    localparam logic [11:0] PCG_OFS_IRQ_CLEAR = 12'h208;
    localparam int PCG_ADDR_W = 12;
    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int PCG_PORTS = 8;
    localparam int PCG_ACG_BIT = 27;
    localparam int PCG_IRQ_W = 2;
    localparam int PCG_IRQ_FAULT_BIT = 0;
    localparam int PCG_IRQ_CHANGE_BIT = 1;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] PCG_GATE_RST = 8'h00;
    localparam logic [1:0] PCG_IRQ_RST = 2'h0;
    localparam logic PCG_ACG_RST = 1'b0;
    // ****************************************
    // Power modes
    // ****************************************
    typedef enum logic [1:0] {
        PCG_MODE_RUN,
        PCG_MODE_SLEEP,
        PCG_MODE_DEEP
    } pcg_mode_e;
endpackage

//--- design/pcg_top.sv
// Port clock gating registers with APB slave, gated port clocks and fault detection
//
// Function
// - Enable bit one delivers port clock
// - Enable bit zero stops port clock
// - Access to gated port gives bus fault
// - All enable bits reset to zero
// - Run mode uses run register
// - Sleep mode uses sleep register
// - Deep sleep uses deep sleep register
// - Sleep registers apply only with auto gating
// - Bits 0 to 7 map ports A to H
// - Bits 31 to 8 read zero, ignore writes
// - Run at 0x108, sleep at 0x118
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module pcg_top
    import pcg_pkg::*;
#(
    parameter int PORTS = PCG_PORTS
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power mode from the system controller
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    // Accesses aimed at the gated ports
    input wire logic port_access,
    input wire logic [2:0] port_access_idx,
    output logic port_bus_fault,
    // Gated port clocks and their enables
    output logic [PORTS-1:0] port_clk,
    output logic [PORTS-1:0] port_clk_en,
    // Interrupt
    output logic irq
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [PORTS-1:0] run_port_clock_enable_ff;
    logic [PORTS-1:0] sleep_port_clock_enable_ff;
    logic [PORTS-1:0] deep_sleep_port_clock_enable_ff;
    logic auto_clock_gating_ff;
    logic [PCG_IRQ_W-1:0] irq_status_ff;
    logic [PCG_IRQ_W-1:0] irq_enable_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic port_bus_fault_ff;
    logic irq_ff;
    logic [PORTS-1:0] port_clk_en_ff;
    logic [PORTS-1:0] port_clk_en_low_ff;
    pcg_mode_e mode;
    logic [PORTS-1:0] nxt_port_clk_en;
    logic [PCG_ADDR_W-1:0] addr;
    logic setup;
    logic wr_commit;
    logic addr_hit;
    logic [31:0] rd_value;
    logic [PCG_IRQ_W-1:0] irq_set;
    logic [PCG_IRQ_W-1:0] irq_clr;

    // ****************************************
    // APB decode
    // ****************************************
    assign addr = paddr[PCG_ADDR_W-1:0];
    assign setup = psel && !penable && !pready_ff;
    // Write lands on the access edge, never on a refused transfer
    assign wr_commit = psel && penable && pready_ff && pwrite && !pslverr_ff;

    always_comb
    begin
        addr_hit = 1'b1;
        rd_value = 32'h0000_0000;
        // Unused bits read zero, narrow fields sit low except the auto gating bit at 27
        case (addr)
            PCG_OFS_RUN_GATE:
                rd_value[PORTS-1:0] = run_port_clock_enable_ff;
            PCG_OFS_SLEEP_GATE:
                rd_value[PORTS-1:0] = sleep_port_clock_enable_ff;
            PCG_OFS_DEEP_GATE:
                rd_value[PORTS-1:0] = deep_sleep_port_clock_enable_ff;
            PCG_OFS_RUN_CFG:
                rd_value[PCG_ACG_BIT] = auto_clock_gating_ff;
            PCG_OFS_IRQ_STATUS:
                rd_value[PCG_IRQ_W-1:0] = irq_status_ff;
            PCG_OFS_IRQ_ENABLE:
                rd_value[PCG_IRQ_W-1:0] = irq_enable_ff;
            PCG_OFS_IRQ_CLEAR:
                rd_value = 32'h0000_0000;
            default:
                addr_hit = 1'b0;
        endcase
        if (paddr[31:PCG_ADDR_W] != '0 || paddr[1:0] != 2'h0)
        begin
            addr_hit = 1'b0;
        end
    end

    // ****************************************
    // APB response
    // ****************************************
    // Answer is prepared in setup so that every bus output is a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else if (setup)
        begin
            pready_ff <= 1'b1;
            pslverr_ff <= !addr_hit;
            prdata_ff <= (pwrite || !addr_hit) ? 32'h0000_0000 : rd_value;
        end
        else
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Gating registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_port_clock_enable_ff <= PCG_GATE_RST;
        end
        else if (wr_commit && addr == PCG_OFS_RUN_GATE)
        begin
            run_port_clock_enable_ff <= pwdata[PORTS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_port_clock_enable_ff <= PCG_GATE_RST;
        end
        else if (wr_commit && addr == PCG_OFS_SLEEP_GATE)
        begin
            sleep_port_clock_enable_ff <= pwdata[PORTS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deep_sleep_port_clock_enable_ff <= PCG_GATE_RST;
        end
        else if (wr_commit && addr == PCG_OFS_DEEP_GATE)
        begin
            deep_sleep_port_clock_enable_ff <= pwdata[PORTS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auto_clock_gating_ff <= PCG_ACG_RST;
        end
        else if (wr_commit && addr == PCG_OFS_RUN_CFG)
        begin
            auto_clock_gating_ff <= pwdata[PCG_ACG_BIT];
        end
    end

    // ****************************************
    // Mode select
    // ****************************************
    // Deep sleep wins when both mode inputs are high
    always_comb
    begin
        if (!auto_clock_gating_ff)
        begin
            mode = PCG_MODE_RUN;
        end
        else if (deep_sleep_mode)
        begin
            mode = PCG_MODE_DEEP;
        end
        else if (sleep_mode)
        begin
            mode = PCG_MODE_SLEEP;
        end
        else
        begin
            mode = PCG_MODE_RUN;
        end
    end

    // Unused enum code falls back to the run enables
    always_comb
    begin
        case (mode)
            PCG_MODE_RUN:
                nxt_port_clk_en = run_port_clock_enable_ff;
            PCG_MODE_SLEEP:
                nxt_port_clk_en = sleep_port_clock_enable_ff;
            PCG_MODE_DEEP:
                nxt_port_clk_en = deep_sleep_port_clock_enable_ff;
            default:
                nxt_port_clk_en = run_port_clock_enable_ff;
        endcase
    end

    // ****************************************
    // Clock gates
    // ****************************************
    // One cycle of latency keeps the gate input a clean flop output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_clk_en_ff <= PCG_GATE_RST;
        end
        else
        begin
            port_clk_en_ff <= nxt_port_clk_en;
        end
    end

    // Enable retimed on the falling edge: it only moves while pclk is low,
    // so the AND gate never cuts a high phase short
    always_ff @(negedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_clk_en_low_ff <= PCG_GATE_RST;
        end
        else
        begin
            port_clk_en_low_ff <= port_clk_en_ff;
        end
    end

    generate
        for (genvar i = 0; i < PORTS; i++)
        begin : g_gate
            // Clock passes while enabled, held low while disabled
            assign port_clk[i] = pclk & port_clk_en_low_ff[i];
        end
    endgenerate

    // ****************************************
    // Gated port fault
    // ****************************************
    // Uses the enable the port sees now, so an access racing an enable
    // write still faults: software must enable a port first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_bus_fault_ff <= 1'b0;
        end
        else
        begin
            port_bus_fault_ff <= port_access && !port_clk_en_ff[port_access_idx];
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_set[PCG_IRQ_FAULT_BIT] = port_access && !port_clk_en_ff[port_access_idx];
    // Change event covers mode switches as well as register writes
    assign irq_set[PCG_IRQ_CHANGE_BIT] = nxt_port_clk_en != port_clk_en_ff;
    assign irq_clr = (wr_commit && addr == PCG_OFS_IRQ_CLEAR) ?
        pwdata[PCG_IRQ_W-1:0] : PCG_IRQ_RST;

    // Set wins so an event in the clear cycle is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_ff <= PCG_IRQ_RST;
        end
        else
        begin
            irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_enable_ff <= PCG_IRQ_RST;
        end
        else if (wr_commit && addr == PCG_OFS_IRQ_ENABLE)
        begin
            irq_enable_ff <= pwdata[PCG_IRQ_W-1:0];
        end
    end

    // Built from the next status, so it moves on the same edge as status, kept registered for a clean pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= |(((irq_status_ff & ~irq_clr) | irq_set) & irq_enable_ff);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port_bus_fault = port_bus_fault_ff;
    assign port_clk_en = port_clk_en_ff;
    assign irq = irq_ff;

endmodule

//--- dv/pcg_checker.sv
// Port-level assertions for the port clock gate block
`timescale 1ns/1ns
module pcg_checker
    import pcg_pkg::*;
#(
    parameter int PORTS = PCG_PORTS
)
(
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Modes, port accesses and clocks
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    input wire logic port_access,
    input wire logic [2:0] port_access_idx,
    input wire logic port_bus_fault,
    input wire logic [PORTS-1:0] port_clk,
    input wire logic [PORTS-1:0] port_clk_en
);
    logic [1:0] mode_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Previous mode, so an enable change can be traced to its cause
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            mode_ff <= 2'h0;
        else
            mode_ff <= {deep_sleep_mode, sleep_mode};
    sequence setup_s;
        psel && !penable;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    reset_clear_a: assert property (!$past(presetn) |-> port_clk_en == '0)
        else $error("enables not clear after reset");
    clk_follow_a: assert property (@(negedge pclk) disable iff (!presetn)
        port_clk == $past(port_clk_en)) else $error("gated clock not following enable");
    fault_gated_a: assert property (
        port_access && !port_clk_en[port_access_idx] |=> port_bus_fault)
        else $error("no fault on gated port");
    fault_quiet_a: assert property (!port_access |=> !port_bus_fault)
        else $error("fault without access");
    en_cause_a: assert property ($changed(port_clk_en) |->
        $past(psel && penable && pwrite, 2) || $past({deep_sleep_mode, sleep_mode}) != $past(mode_ff))
        else $error("enable changed without cause");
    zero_wait_a: assert property (setup_s |=> pready)
        else $error("no answer in access cycle");
    misalign_err_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pready && pslverr)
        else $error("misaligned access not refused");
    reserved_zero_a: assert property (pready && !pslverr && !pwrite &&
        (paddr[11:0] == PCG_OFS_RUN_GATE || paddr[11:0] == PCG_OFS_SLEEP_GATE)
        |-> prdata[31:8] == 24'h0) else $error("reserved bits read nonzero");
endmodule
bind pcg_top pcg_checker #(.PORTS(PORTS)) u_pcg_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .deep_sleep_mode(deep_sleep_mode), .port_access(port_access),
    .port_access_idx(port_access_idx), .port_bus_fault(port_bus_fault),
    .port_clk(port_clk), .port_clk_en(port_clk_en));

//--- dv/pcg_port_model.sv
// Model of the eight gated port modules: tick counters and access driver
`timescale 1ns/1ns
module pcg_port_model
(
    // Clock, reset and gated clocks
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] port_clk,
    // Access requests from the bench
    input wire logic go,
    input wire logic [2:0] go_idx,
    // Access towards the gate block
    output logic port_access,
    output logic [2:0] port_access_idx,
    output int ticks [8]
);
    // A port advances only on its own gated clock
    for (genvar i = 0; i < 8; i++)
    begin : g_cnt
        always @(posedge port_clk[i] or negedge presetn)
            if (!presetn)
                ticks[i] <= 0;
            else
                ticks[i] <= ticks[i] + 1;
    end
    // Idle index keeps moving so a stale value never looks valid
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            port_access <= 1'b0;
        else
            port_access <= go;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            port_access_idx <= 3'h0;
        else
            port_access_idx <= go ? go_idx : ~port_access_idx;
endmodule

//--- dv/port_clock_gate_regs_bench.sv
// Self-checking bench for the port clock gate block
`timescale 1ns/1ns
module port_clock_gate_regs_bench
    import pcg_pkg::*;
();
    typedef struct packed
    {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
        logic err;
    } pcg_row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic pready, pslverr, port_access, port_bus_fault, irq, e, go = 1'b0;
    logic sleep_mode = 1'b0, deep_sleep_mode = 1'b0;
    logic [2:0] port_access_idx, go_idx = 3'h0;
    logic [7:0] port_clk, port_clk_en;
    int ticks [8];
    int mismatches = 0, n_checks = 0, cycles = 0, faults = 0, t0, s0, s1;
    pcg_row_s rows [8] = '{
        '{PCG_OFS_RUN_GATE, 32'hffff_ffa5, 32'h0000_00a5, 1'b0},
        '{PCG_OFS_SLEEP_GATE, 32'h1234_565a, 32'h0000_005a, 1'b0},
        '{PCG_OFS_DEEP_GATE, 32'hffff_ff3c, 32'h0000_003c, 1'b0},
        '{PCG_OFS_RUN_CFG, 32'hffff_ffff, 32'h0800_0000, 1'b0},
        '{PCG_OFS_IRQ_ENABLE, 32'hffff_ffff, 32'h0000_0003, 1'b0},
        '{PCG_OFS_IRQ_CLEAR, 32'h0000_0003, 32'h0, 1'b0},
        '{12'h300, 32'h1, 32'h0, 1'b1},
        '{12'h10a, 32'h1, 32'h0, 1'b1}};
    pcg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
        .port_access(port_access), .port_access_idx(port_access_idx),
        .port_bus_fault(port_bus_fault), .port_clk(port_clk), .port_clk_en(port_clk_en),
        .irq(irq));
    pcg_port_model u_ports (.pclk(pclk), .presetn(presetn), .port_clk(port_clk), .go(go),
        .go_idx(go_idx), .port_access(port_access), .port_access_idx(port_access_idx),
        .ticks(ticks));
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        faults += (port_bus_fault === 1'b1);
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mode(input logic s, dp, input logic [7:0] exp);
        @(posedge pclk);
        sleep_mode <= s;
        deep_sleep_mode <= dp;
        repeat (2) @(negedge pclk);
        check({24'h0, port_clk_en}, {24'h0, exp});
    endtask
    task automatic hit(input logic [2:0] i, input int n);
        t0 = faults;
        @(posedge pclk);
        go <= 1'b1;
        go_idx <= i;
        @(posedge pclk);
        go <= 1'b0;
        repeat (4) @(negedge pclk);
        check(faults - t0, n);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            check({31'h0, e}, {31'h0, rows[i].err});
            apb(1'b0, rows[i].addr, 32'h0);
            check(r, rows[i].rexp);
        end
        $display("test registers done");
        mode(1'b0, 1'b0, 8'ha5);
        mode(1'b1, 1'b0, 8'h5a);
        mode(1'b1, 1'b1, 8'h3c);
        apb(1'b1, PCG_OFS_RUN_CFG, 32'h0);
        mode(1'b1, 1'b1, 8'ha5);
        mode(1'b0, 1'b0, 8'ha5);
        s0 = ticks[0];
        s1 = ticks[1];
        repeat (10) @(negedge pclk);
        check(ticks[0] - s0, 10);
        check(ticks[1] - s1, 0);
        $display("test modes done");
        apb(1'b1, PCG_OFS_IRQ_CLEAR, 32'h3);
        hit(3'h0, 0);
        hit(3'h1, 1);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, PCG_OFS_IRQ_ENABLE, 32'h0);
        apb(1'b1, PCG_OFS_IRQ_CLEAR, 32'h3);
        hit(3'h6, 1);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, PCG_OFS_IRQ_STATUS, 32'h0);
        check(r, 32'h1);
        apb(1'b0, PCG_OFS_RUN_GATE, 32'h0);
        apb(1'b1, PCG_OFS_RUN_GATE, r | 32'h2);
        hit(3'h1, 0);
        apb(1'b0, PCG_OFS_IRQ_STATUS, 32'h0);
        check(r, 32'h3);
        $display("test faults done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(negedge pclk);
        check({24'h0, port_clk_en}, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, rows[i].addr, 32'h0);
            check(r, 32'h0);
        end
        $display("test reset done");
        wrap_up();
    end
endmodule
